// ==== verilog/afecfg_pkg.sv ====
/*
 * afecfg_pkg: register map, field positions and frame layout of the
 * front-end configuration bank.
 * assumes: included before the bank module; no state of its own.
 */
`default_nettype none
package afecfg_pkg;
    localparam int FRAME_BITS  = 16;
    localparam int SEL_BITS    = 3;
    localparam int CODE_BITS   = 10;
    // register selects
    localparam logic [2:0] SEL_GAIN_INPUT   = 3'h0;
    localparam logic [2:0] SEL_POWER_FILTER = 3'h1;
    localparam logic [2:0] SEL_CLAMP_CTRL   = 3'h2;
    localparam logic [2:0] SEL_OUTPUT_CODE  = 3'h3;
    // reset values: soft reset bit released, clamp field 9, all other fields zero
    localparam logic [15:0] RST_GAIN_INPUT   = 16'h0000;
    localparam logic [15:0] RST_POWER_FILTER = 16'h0001;
    localparam logic [15:0] RST_CLAMP_CTRL   = 16'h8048;
    localparam logic [15:0] RST_OUTPUT_CODE  = 16'h1003;
    // field positions
    localparam int GAIN_LSB = 5;
    localparam int GAIN_MSB = 12;
    localparam int SRC_BIT  = 15;
    localparam int SLP_BIT  = 3;
    localparam int STANDBY_BIT_BIT = 4;
    localparam int TMODE_LSB = 5;
    localparam int TMODE_MSB = 7;
    localparam int SHA_LSB  = 8;
    localparam int SHA_MSB  = 9;
    localparam int BSW_LSB  = 10;
    localparam int BSW_MSB  = 13;
    localparam int CLV_LSB  = 3;
    localparam int CLV_MSB  = 7;
    localparam int HSTOP_LSB = 8;
    localparam int HSTOP_MSB = 9;
    localparam int HGAIN_LSB = 10;
    localparam int HGAIN_MSB = 11;
    localparam int SPD_BIT  = 12;
    localparam int INV_BIT  = 13;
    localparam int SRST_BIT = 15;
    localparam int CBIAS_BIT = 3;
    localparam int OCODE_LSB = 4;
    localparam int OCODE_MSB = 5;
    localparam int AVG_BIT  = 6;
    localparam int OTIM_LSB = 7;
    localparam int OTIM_MSB = 8;
    localparam int EDGE_BIT = 9;
    // clamp level offset in codes
    localparam logic [6:0] CLAMP_OFFSET = 7'h0e;
    // output code formats
    typedef enum logic [1:0] {
        AFECFG_FMT_BIN      = 2'b00,
        AFECFG_FMT_GRAY     = 2'b01,
        AFECFG_FMT_DIFF_BIN = 2'b10,
        AFECFG_FMT_DIFF_GRAY = 2'b11
    } afecfg_fmt_e;
    // decoded controls handed to the analogue and timing logic
    typedef struct packed {
        logic [7:0] gain_code;
        logic       input_source_select;
        logic       sleep_bit;
        logic       standby_bit;
        logic [2:0] test_mode;
        logic [1:0] sha_filter_select;
        logic [3:0] black_sample_time_select;
        logic [6:0] clamp_level;    // field 31 gives 76, needs seven bits
        logic [1:0] fast_leadin_stop_select;
        logic [1:0] fast_leadin_gain_select;
        logic       speed_grade_select;
        logic       timing_input_invert;
        logic       soft_reset;
        logic       center_bias_off;
        logic       four_line_average;
        afecfg_fmt_e out_format;
        logic [2:0] ref_pair_first;
        logic       sample_clock_falling;
    } afecfg_ctrl_s;
endpackage
`default_nettype wire

// ==== verilog/afecfg_bank.sv ====
/*
 * afecfg_bank: three-wire serial configuration bank of the front end,
 * plus the output code formatter and timing-input polarity it steers.
 * assumes: the serial clock comes from the host and runs during a frame,
 * plus one rise after a cut frame; chip select, serial clock and data are pins.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RL1: gain code bits 5-12 of register 0 set amplifier gain.
// RL2: in direct converter mode gain code maps linearly, not logarithmically.
// RL3: bit 15 of register 0 chooses double sampler or direct converter.
// RL4: register 1 bit 3 sleeps everything; host restarts with offset calibration.
// RL5: register 1 bit 4 is standby; host waits 50 lines after leaving.
// RL6: host keeps test output-mode bits at zero.
// RL7: register 1 bits 8-9 pick hold amplifier filter.
// RL8: register 1 bits 10-13 pick black-level sampling time constant.
// RL9: clamp level equals twice register 2 bits 3-7 plus 14.
// RL10: register 2 bits 8-11 set fast lead-in; host steps gain by one.
// RL11: register 2 bit 12 picks speed grade, 36 or 25 MHz.
// RL12: register 2 bit 13 high keeps timing inputs, low inverts them.
// RL13: register 2 bit 15 is active-low soft reset.
// RL14: register 3 bit 3 turns centre bias off in direct mode.
// RL15: register 3 bit 6 averages clamp detection over four lines.
// RL16: register 3 bits 4-5 pick binary, Gray or differential output code.
// RL17: register 3 bits 7-8 pick the reference output sample pair.
// RL18: register 3 bit 9 picks sample clock edge against black pulse.
// RL19: differential codes need reconstruction logic in the receiver.
// RL20: host sends sixteen serial clocks while chip select is low.
// RL21: data sampled on serial clock rise; low three bits select register.
// RL22: frames shorter than sixteen bits are discarded.
// RL23: host never writes register selects 4 to 7.
// RL24: timing select 00 to 11 maps third-fourth through sixth-seventh pair.
// RL25: differential code is current minus previous sample, modulo 1024.
module afecfg_bank #(
    parameter int CODE_W = afecfg_pkg::CODE_BITS
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      serial_clk_i,
    input  wire logic                      chip_select_n_i,
    input  wire logic                      serial_data_in_i,
    input  wire logic                      sample_pulse_input_i,
    input  wire logic                      black_sample_pulse_input_i,
    input  wire logic                      pre_blanking_input_i,
    input  wire logic                      sample_valid_i,
    input  wire logic [CODE_W-1:0]         sample_code_i,
    output logic                           sample_pulse_o,
    output logic                           black_sample_pulse_o,
    output logic                           pre_blanking_o,
    output logic                           code_valid_o,
    output logic [CODE_W-1:0]              code_o,
    output afecfg_pkg::afecfg_ctrl_s       ctrl_o
);

    // refuse code widths the gray and difference logic is not sized for
    if (CODE_W < 2 || CODE_W > 16) begin
        $error("afecfg_bank: CODE_W out of range");
    end

    // gray conversion used by both gray formats
    function automatic logic [CODE_W-1:0] to_gray(input logic [CODE_W-1:0] v);
        to_gray = v ^ (v >> 1);
    endfunction

    // link-side state: runs on the host's serial clock only
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0]  count;
        logic [15:0] word;
        logic        tgl;
    } afecfg_link_s;

    afecfg_link_s lk_q;
    afecfg_link_s lk_d;

    // core-side state
    typedef struct packed {
        logic [2:0]  cs_sync;
        logic [2:0]  tgl_sync;
        logic        tgl_seen;
        logic [15:0] reg0;
        logic [15:0] reg1;
        logic [15:0] reg2;
        logic [15:0] reg3;
        logic [2:0]  pin_a;
        logic [2:0]  pin_b;
        logic [2:0]  pin_c;
        logic [CODE_W-1:0] prev;
        logic        code_valid;
        logic [CODE_W-1:0] code;
        logic [2:0]  timing;
        afecfg_pkg::afecfg_ctrl_s ctrl;
    } afecfg_core_s;

    afecfg_core_s cr_q;
    afecfg_core_s cr_d;

    // serial shift on the link clock; a rise with select high clears the count,
    // so a cut frame needs one such rise before the next frame starts
    always_comb begin
        lk_d = lk_q;
        // RL21 sample on rise
        lk_d.shift = {lk_q.shift[14:0], serial_data_in_i};
        lk_d.count = lk_q.count + 5'h01;
        if (chip_select_n_i) begin
            lk_d.count = 5'h00;
            lk_d.shift = lk_q.shift;
        end else if (lk_q.count == 5'h0f) begin
            // RL22 only full frames commit
            lk_d.word  = {lk_q.shift[14:0], serial_data_in_i};
            lk_d.tgl   = ~lk_q.tgl;
            lk_d.count = 5'h00;
        end
    end

    // the serial clock stops between frames, so no synchronised reset could
    // ever reach these flops; the core reset clears them directly while idle
    always_ff @(posedge serial_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end

    // word crossing: toggle event, word held stable until the next frame
    always_comb begin
        logic [2:0] sel;
        logic       commit;
        sel    = 3'h0;
        commit = 1'b0;
        cr_d = cr_q;
        cr_d.cs_sync  = {cr_q.cs_sync[1:0], chip_select_n_i};
        cr_d.tgl_sync = {cr_q.tgl_sync[1:0], lk_q.tgl};
        commit = (cr_q.tgl_sync[2] == cr_q.tgl_sync[1]) && (cr_q.tgl_sync[1] != cr_q.tgl_seen);
        if (commit) begin
            cr_d.tgl_seen = cr_q.tgl_sync[1];
        end
        // RL21 low bits select register
        sel = lk_q.word[2:0];
        if (commit) begin
            unique case (sel)
                afecfg_pkg::SEL_GAIN_INPUT:   cr_d.reg0 = lk_q.word;
                afecfg_pkg::SEL_POWER_FILTER: cr_d.reg1 = lk_q.word;
                afecfg_pkg::SEL_CLAMP_CTRL:   cr_d.reg2 = lk_q.word;
                afecfg_pkg::SEL_OUTPUT_CODE:  cr_d.reg3 = lk_q.word;
                default: ; // test selects are ignored
            endcase
        end

        // field decode into the control bundle
        // RL1 gain code
        cr_d.ctrl.gain_code = cr_q.reg0[afecfg_pkg::GAIN_MSB:afecfg_pkg::GAIN_LSB];
        // RL3 source; RL2 gain law follows it downstream
        cr_d.ctrl.input_source_select = cr_q.reg0[afecfg_pkg::SRC_BIT];
        // RL4 sleep
        cr_d.ctrl.sleep_bit = cr_q.reg1[afecfg_pkg::SLP_BIT];
        // RL5 standby
        cr_d.ctrl.standby_bit = cr_q.reg1[afecfg_pkg::STANDBY_BIT_BIT];
        cr_d.ctrl.test_mode = cr_q.reg1[afecfg_pkg::TMODE_MSB:afecfg_pkg::TMODE_LSB];
        // RL7 filter select
        cr_d.ctrl.sha_filter_select = cr_q.reg1[afecfg_pkg::SHA_MSB:afecfg_pkg::SHA_LSB];
        // RL8 black time constant
        cr_d.ctrl.black_sample_time_select = cr_q.reg1[afecfg_pkg::BSW_MSB:afecfg_pkg::BSW_LSB];
        // RL9 clamp level
        cr_d.ctrl.clamp_level = {1'b0, cr_q.reg2[afecfg_pkg::CLV_MSB:afecfg_pkg::CLV_LSB], 1'b0}
                                + afecfg_pkg::CLAMP_OFFSET;
        // RL10 lead-in controls
        cr_d.ctrl.fast_leadin_stop_select = cr_q.reg2[afecfg_pkg::HSTOP_MSB:afecfg_pkg::HSTOP_LSB];
        cr_d.ctrl.fast_leadin_gain_select = cr_q.reg2[afecfg_pkg::HGAIN_MSB:afecfg_pkg::HGAIN_LSB];
        // RL11 speed grade
        cr_d.ctrl.speed_grade_select = cr_q.reg2[afecfg_pkg::SPD_BIT];
        // RL12 input polarity
        cr_d.ctrl.timing_input_invert = ~cr_q.reg2[afecfg_pkg::INV_BIT];
        // RL13 soft reset, active while the bit is low
        cr_d.ctrl.soft_reset = ~cr_q.reg2[afecfg_pkg::SRST_BIT];
        // RL14 centre bias only acts in direct mode
        cr_d.ctrl.center_bias_off = cr_q.reg3[afecfg_pkg::CBIAS_BIT] & cr_q.reg0[afecfg_pkg::SRC_BIT];
        // RL15 averaging
        cr_d.ctrl.four_line_average = cr_q.reg3[afecfg_pkg::AVG_BIT];
        // RL16 format
        cr_d.ctrl.out_format = afecfg_pkg::afecfg_fmt_e'(cr_q.reg3[afecfg_pkg::OCODE_MSB:afecfg_pkg::OCODE_LSB]);
        // RL24 ascending pair map: 3 + select
        cr_d.ctrl.ref_pair_first = 3'h3 + {1'b0, cr_q.reg3[afecfg_pkg::OTIM_MSB:afecfg_pkg::OTIM_LSB]};
        // RL17 pair select carried above
        // RL18 edge select
        cr_d.ctrl.sample_clock_falling = cr_q.reg3[afecfg_pkg::EDGE_BIT];

        // timing inputs: three-stage synchronisers, change when stages 2,3 agree
        cr_d.pin_a = {cr_q.pin_a[1:0], sample_pulse_input_i};
        cr_d.pin_b = {cr_q.pin_b[1:0], black_sample_pulse_input_i};
        cr_d.pin_c = {cr_q.pin_c[1:0], pre_blanking_input_i};
        // RL12 apply polarity
        if (cr_q.pin_a[2] == cr_q.pin_a[1]) begin
            cr_d.timing[0] = cr_q.pin_a[2] ^ cr_q.ctrl.timing_input_invert;
        end
        if (cr_q.pin_b[2] == cr_q.pin_b[1]) begin
            cr_d.timing[1] = cr_q.pin_b[2] ^ cr_q.ctrl.timing_input_invert;
        end
        if (cr_q.pin_c[2] == cr_q.pin_c[1]) begin
            cr_d.timing[2] = cr_q.pin_c[2] ^ cr_q.ctrl.timing_input_invert;
        end

        // output formatter; sleep and soft reset hold it idle
        cr_d.code_valid = 1'b0;
        if (cr_q.ctrl.soft_reset || cr_q.ctrl.sleep_bit) begin
            cr_d.prev = '0;
            cr_d.code = '0;
        end else if (sample_valid_i) begin
            cr_d.code_valid = 1'b1;
            cr_d.prev = sample_code_i;
            // RL16 format select
            unique case (cr_q.ctrl.out_format)
                afecfg_pkg::AFECFG_FMT_BIN:  cr_d.code = sample_code_i;
                afecfg_pkg::AFECFG_FMT_GRAY: cr_d.code = to_gray(sample_code_i);
                // RL25 difference wraps modulo code range
                afecfg_pkg::AFECFG_FMT_DIFF_BIN:  cr_d.code = sample_code_i - cr_q.prev;
                afecfg_pkg::AFECFG_FMT_DIFF_GRAY: cr_d.code = to_gray(sample_code_i - cr_q.prev);
            endcase
        end

        if (rst_i) begin
            cr_d = '0;
            cr_d.reg0 = afecfg_pkg::RST_GAIN_INPUT;
            cr_d.reg1 = afecfg_pkg::RST_POWER_FILTER;
            cr_d.reg2 = afecfg_pkg::RST_CLAMP_CTRL;
            cr_d.reg3 = afecfg_pkg::RST_OUTPUT_CODE;
            cr_d.ctrl.clamp_level = 7'h20;
            cr_d.ctrl.ref_pair_first = 3'h3;
            cr_d.ctrl.timing_input_invert = 1'b0;
            cr_d.tgl_seen = 1'b0;   // link toggle is cleared by the same reset
        end
    end

    // core register; reset is synchronous so tgl_seen may load a signal
    always_ff @(posedge core_clk_i) begin
        cr_q <= cr_d;
    end

    // outputs straight from flops
    assign sample_pulse_o       = cr_q.timing[0];
    assign black_sample_pulse_o = cr_q.timing[1];
    assign pre_blanking_o       = cr_q.timing[2];
    assign code_valid_o         = cr_q.code_valid;
    assign code_o               = cr_q.code;
    assign ctrl_o               = cr_q.ctrl;

endmodule
`default_nettype wire

// ==== sim/afecfg_host.sv ====
/* afecfg_host: serial controller on the far side of the configuration bank.
   assumes the bench calls send; the link clock toggles inside frames, plus one rise after a cut frame. */
`timescale 1ns/100ps
`default_nettype none
module afecfg_host (
    output logic serial_clk_o,
    output logic chip_select_n_o,
    output logic serial_data_o
);
    // idle: clock low, select high
    initial {serial_clk_o, chip_select_n_o, serial_data_o} = 3'b010;
    task automatic send(input logic [15:0] w, input int n);
        chip_select_n_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            serial_data_o = w[i];
            #80 serial_clk_o = 1'b1;
            #80 serial_clk_o = 1'b0;
        end
        #80 chip_select_n_o = 1'b1;
        // released line shows the inverse of its last bit, never a stale copy
        serial_data_o = ~serial_data_o;
        // a cut frame needs one rise with select high to restart the count
        if (n < 16) begin
            #80 serial_clk_o = 1'b1;
            #80 serial_clk_o = 1'b0;
        end
        // keeps frames well over 400 ns apart
        #480;
    endtask
endmodule
`default_nettype wire

// ==== sim/afecfg_bank_chk.sv ====
/* afecfg_bank_chk: sample path, pin polarity and bank quiet-time checks.
   assumes only the bank's ports; bound from the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
module afecfg_bank_chk #(
    parameter int CODE_W = 10
) (
    input wire logic                     core_clk_i,
    input wire logic                     rst_i,
    input wire logic                     serial_clk_i,
    input wire logic                     chip_select_n_i,
    input wire logic                     serial_data_in_i,
    input wire logic                     sample_pulse_input_i,
    input wire logic                     black_sample_pulse_input_i,
    input wire logic                     pre_blanking_input_i,
    input wire logic                     sample_valid_i,
    input wire logic [CODE_W-1:0]        sample_code_i,
    input wire logic                     sample_pulse_o,
    input wire logic                     black_sample_pulse_o,
    input wire logic                     pre_blanking_o,
    input wire logic                     code_valid_o,
    input wire logic [CODE_W-1:0]        code_o,
    input wire afecfg_pkg::afecfg_ctrl_s ctrl_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // a sample counts only while awake and out of soft reset
    sequence s_accept;
        sample_valid_i && !ctrl_o.sleep_bit && !ctrl_o.soft_reset;
    endsequence
    // select high long enough for any earlier frame to have committed
    sequence s_idle;
        chip_select_n_i [*8];
    endsequence
    // pins and polarity settled past the synchroniser depth
    sequence s_pins_still;
        ($stable({sample_pulse_input_i, black_sample_pulse_input_i, pre_blanking_input_i}) && $stable(ctrl_o)) [*7];
    endsequence
    a_sample_taken: assert property (s_accept |=> code_valid_o)
        else $error("accepted sample gave no code");
    a_sample_refused: assert property (sample_valid_i && (ctrl_o.sleep_bit || ctrl_o.soft_reset) |=> !code_valid_o)
        else $error("sample taken while asleep or in soft reset");
    a_valid_cause: assert property (code_valid_o |-> $past(sample_valid_i))
        else $error("code valid without a sample");
    a_binary_pass: assert property (code_valid_o && ctrl_o.out_format == afecfg_pkg::AFECFG_FMT_BIN
        |-> code_o == $past(sample_code_i)) else $error("binary code differs from sample");
    a_gray_map: assert property (code_valid_o && ctrl_o.out_format == afecfg_pkg::AFECFG_FMT_GRAY
        |-> code_o == ($past(sample_code_i) ^ ($past(sample_code_i) >> 1))) else $error("gray code wrong");
    a_code_hold: assert property (!code_valid_o && !$past(ctrl_o.sleep_bit || ctrl_o.soft_reset)
        |-> $stable(code_o)) else $error("code changed without a sample");
    a_idle_clear: assert property ($past(ctrl_o.sleep_bit || ctrl_o.soft_reset)
        |-> !code_valid_o && code_o == '0) else $error("code not cleared while asleep or in soft reset");
    a_bank_quiet: assert property (s_idle |-> $stable(ctrl_o))
        else $error("controls changed without a frame");
    a_pin_polarity: assert property (s_pins_still |->
        ((sample_pulse_o ^ sample_pulse_input_i) == (black_sample_pulse_o ^ black_sample_pulse_input_i))
        && ((pre_blanking_o ^ pre_blanking_input_i) == (sample_pulse_o ^ sample_pulse_input_i)))
        else $error("timing pins disagree in polarity");
endmodule
bind afecfg_bank afecfg_bank_chk #(.CODE_W(CODE_W)) u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .serial_clk_i(serial_clk_i), .chip_select_n_i(chip_select_n_i),
    .serial_data_in_i(serial_data_in_i), .sample_pulse_input_i(sample_pulse_input_i),
    .black_sample_pulse_input_i(black_sample_pulse_input_i), .pre_blanking_input_i(pre_blanking_input_i),
    .sample_valid_i(sample_valid_i), .sample_code_i(sample_code_i), .sample_pulse_o(sample_pulse_o),
    .black_sample_pulse_o(black_sample_pulse_o), .pre_blanking_o(pre_blanking_o),
    .code_valid_o(code_valid_o), .code_o(code_o), .ctrl_o(ctrl_o));
`default_nettype wire

// ==== sim/afecfg_bank_tb.sv ====
/* afecfg_bank_tb: drives the bank through its serial port and sample path.
   assumes afecfg_host as serial controller and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module afecfg_bank_tb;
    logic                     core_clk, rst, sclk, cs_n, serial_data_in, sv, sp, bp, pb, spo, bpo, pbo, cv;
    logic [9:0]               scode, code, prev;
    logic [15:0]              w;
    logic [15:0]              r [4];
    afecfg_pkg::afecfg_ctrl_s ctrl, e;
    int                       mismatches, tests_run, seed;
    localparam logic [15:0] MSK [4] = '{16'h9fe0, 16'h3f10, 16'h3ff8, 16'h03f8};
    localparam logic [15:0] FIX [4] = '{16'h0000, 16'h0001, 16'h8002, 16'h1003};
    always #25 core_clk = ~core_clk;
    afecfg_host host (.serial_clk_o(sclk), .chip_select_n_o(cs_n), .serial_data_o(serial_data_in));
    afecfg_bank dut (.core_clk_i(core_clk), .rst_i(rst), .serial_clk_i(sclk), .chip_select_n_i(cs_n),
        .serial_data_in_i(serial_data_in), .sample_pulse_input_i(sp), .black_sample_pulse_input_i(bp),
        .pre_blanking_input_i(pb), .sample_valid_i(sv), .sample_code_i(scode), .sample_pulse_o(spo),
        .black_sample_pulse_o(bpo), .pre_blanking_o(pbo), .code_valid_o(cv), .code_o(code), .ctrl_o(ctrl));
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one whole frame, then wait past the commit; reserved selects leave the model alone
    task automatic wr(input logic [15:0] v);
        host.send(v, 16);
        if (v[2:0] < 3'h4) r[v[2:0]] = v;
        repeat (10) @(posedge core_clk);
        #2;
    endtask
    // decode expected from the model; invert sense is judged at the pins instead
    task automatic chk_ctrl;
        afecfg_pkg::afecfg_ctrl_s g;
        g = ctrl;
        g.timing_input_invert = 1'b0;
        e = '{r[0][12:5], r[0][15], r[1][3], r[1][4], r[1][7:5], r[1][9:8], r[1][13:10], {r[2][7:3], 1'b0} + 7'h0e,
              r[2][9:8], r[2][11:10], r[2][12], 1'b0, ~r[2][15], r[3][3] & r[0][15], r[3][6],
              afecfg_pkg::afecfg_fmt_e'(r[3][5:4]), 3'h3 + {1'b0, r[3][8:7]}, r[3][9]};
        chk("ctrl", 48'(e), 48'(g));
    endtask
    // one sample; difference is modulo 1024 by the 10-bit wrap
    task automatic smp(input logic [9:0] s, input logic acc);
        logic [9:0] d;
        d = r[3][5] ? s - prev : s;
        if (r[3][4]) d = d ^ (d >> 1);
        @(posedge core_clk) #2 {sv, scode} = {1'b1, s};
        @(posedge core_clk) #2 sv = 1'b0;
        chk("code_valid", 48'(acc), 48'(cv));
        if (acc) chk("code", 48'(d), 48'(code));
        prev = acc ? s : 10'h000;
    endtask
    initial begin
        {core_clk, rst, sv, scode, sp, bp, pb, prev} = {3'b000, 23'h0};
        // a clean rising edge so the link flops see their reset
        #1 rst = 1'b1;
        {seed, mismatches, tests_run} = {32'd48475, 64'd0};
        {r[0], r[1], r[2], r[3]} = {16'h0000, 16'h0001, 16'h8048, 16'h1003};
        repeat (5) @(posedge core_clk);
        #2 rst = 1'b0;
        repeat (3) @(posedge core_clk);
        #2 chk_ctrl();
        for (int i = 0; i < 16; i++) begin
            w = (16'($random(seed)) & MSK[i % 4]) | FIX[i % 4];
            wr(w);
            chk_ctrl();
        end
        for (int s = 4; s < 8; s++) begin
            wr((16'($random(seed)) & 16'hfff8) | 16'(s));
            chk_ctrl();
        end
        host.send(16'h7ffa, 10);
        repeat (10) @(posedge core_clk);
        #2 chk_ctrl();
        // every output format, including a wrap of the difference
        for (int f = 0; f < 4; f++) begin
            wr(16'h1003 | 16'(f << 4));
            smp(10'h3ff, 1'b1);
            smp(10'h001, 1'b1);
            repeat (3) smp(10'($random(seed)), 1'b1);
        end
        // sleep and soft reset refuse samples and clear history
        wr(16'h0009);
        smp(10'h123, 1'b0);
        wr(16'h0001);
        wr(16'h004a);
        smp(10'h155, 1'b0);
        wr(16'h804a);
        smp(10'h2aa, 1'b1);
        for (int k = 0; k < 2; k++) begin
            wr(16'h804a | 16'(k << 13));
            repeat (3) begin
                @(posedge core_clk) #2 {sp, bp, pb} = 3'($random(seed));
                repeat (6) @(posedge core_clk);
                #2 chk("pins", 48'({sp, bp, pb} ^ {3{~r[2][13]}}), 48'({spo, bpo, pbo}));
            end
        end
        complete_run();
    end
    // watchdog well beyond the expected run of about 116 us
    initial begin
        #1000000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
